// ---- hdl/spi_pkg.sv ----
package spi_pkg;
   // Frame shape: sixteen bits, most significant bit first.
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] LAST_BIT = 5'h0F;
   localparam int WRITE_FLAG_BIT = 15;
   localparam int ADDR_MSB = 14;
   localparam int ADDR_LSB = 8;
   // Paged register space.
   localparam int PAGE_COUNT = 13;
   localparam int WORDS_PER_PAGE = 64;
   localparam int MEM_ADDR_W = 10;
   localparam logic [6:0] PAGE_SELECT_ADDR = 7'h00;
   localparam logic [5:0] PAGE_SELECT_WORD = 6'h00;
   localparam logic [5:0] PRODUCT_CODE_WORD = 6'h3F;
   localparam logic [7:0] PAGE_OUTPUT = 8'h00;
   localparam logic [7:0] PAGE_CONTROL = 8'h03;
   localparam logic [7:0] PAGE_SERIAL = 8'h04;
   localparam logic [7:0] PAGE_FILTER_FIRST = 8'h05;
   localparam logic [7:0] PAGE_FILTER_LAST = 8'h0C;
   localparam logic [7:0] PAGE_RESET = 8'h00;
   // Identification value; this value is arbitrary.
   localparam logic [15:0] PRODUCT_CODE_DEFAULT = 16'h5A3C;
   // Idle levels of the synchronised sclk (bit 0) and ss_n (bit 1) lines.
   localparam logic [2:0] SYNC_IDLE = 3'h3;
   // Link timing.
   localparam real CLK_PERIOD_NS = 50.0;
   localparam real SCLK_MIN_PERIOD_NS = 62.5;
   localparam int SCLK_HALF_RATE_MIN = int'($ceil(SCLK_MIN_PERIOD_NS / 2.0 / CLK_PERIOD_NS));
   localparam int SCLK_HALF_SYNC_MIN = 3;
   localparam int SCLK_HALF_CYCLES = 4;
   // Controller registers on the APB side.
   localparam logic [7:0] CMD_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] RX_OFFSET = 8'h08;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_DONE_BIT = 1;
   localparam int STATUS_DRDY_BIT = 2;
endpackage : spi_pkg

// ---- hdl/spi_link_if.sv ----
interface spi_link_if;
   logic sclk;       // Serial clock, idles high.
   logic ss_n;       // Slave select, active low.
   logic mosi;       // Master to slave data.
   logic miso_o;     // Slave data driven value.
   logic miso_oe;    // Slave drives miso while high.
   logic miso;       // Resolved line; a pull-up holds it high when undriven.
   logic data_ready; // New data pulse from the device.
   assign miso = miso_oe ? miso_o : 1'b1;
   modport device (input sclk, input ss_n, input mosi, output miso_o, output miso_oe,
      output data_ready);
   modport host (output sclk, output ss_n, output mosi, input miso, input data_ready);
endinterface : spi_link_if

// ---- hdl/spi_reg_device.sv ----
// Overview of operation
// - Slave only, mode 3, MSB first, 16 bits
// - Master keeps serial clock at most 16 MHz
// - Sensor results keep loading into output registers
// - Data-ready pin pulses on each new data
// - Thirteen pages of 64 sixteen-bit registers
// - Page select writes choose, reads report page
// - Page select decoded at address zero everywhere
// - Page codes 0, 3, 4, 5-12 are used
// - Read data shifts out during next command
// - Even address low byte, odd address high
// - Master writes low byte before high byte
// - Register changes only when high byte written
// - Write frame: one, address, data byte
// - Page zero active after reset
// - Read takes two frames, data in second
// - Read frame: zero, address, ignored byte
// - Request taken only after sixteen clocks
// - Product code reads fixed every time
//
// Implementation choice: register access over APB.
module spi_reg_device #(
   parameter logic [15:0] PRODUCT_CODE = spi_pkg::PRODUCT_CODE_DEFAULT
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   spi_link_if.device link,
   input wire logic load_valid_in,
   input wire logic [5:0] load_word_in,
   input wire logic [15:0] load_value_in,
   input wire logic load_done_in,
   output logic [7:0] active_page_out
);

   // All control state of the port lives in one record.
   typedef struct packed {
      logic [2:0] sync1;     // First synchroniser stage: mosi, ss_n, sclk.
      logic [2:0] sync2;     // Second synchroniser stage.
      logic sclk_prev;       // Synchronised sclk one cycle back.
      logic ss_prev;         // Synchronised ss_n one cycle back.
      logic [4:0] bit_cnt;   // Rising edges seen in the current frame.
      logic [15:0] rx;       // Receive shift register.
      logic [15:0] reply;    // Word to send in the next frame.
      logic [15:0] tx;       // Transmit shift register.
      logic miso;            // Driven serial output bit.
      logic miso_oe;         // Serial output enable.
      logic [7:0] page;      // Active page code.
      logic pend_valid;      // A low byte waits for its high byte.
      logic [5:0] pend_word; // Word that the waiting low byte belongs to.
      logic [7:0] pend_low;  // The waiting low byte.
      logic drdy;            // Data-ready pulse register.
   } dev_state_t;

   // Reset record: lines idle, page zero active, nothing pending.
   localparam dev_state_t DEV_RESET = '{
      sync1: spi_pkg::SYNC_IDLE,
      sync2: spi_pkg::SYNC_IDLE,
      sclk_prev: 1'b1,
      ss_prev: 1'b1,
      page: spi_pkg::PAGE_RESET,
      default: '0
   };

   dev_state_t st_ff;  // Registered state.
   dev_state_t nxt_st; // Next state.

   // Register storage for every page; one word per location.
   logic [15:0] reg_mem [0:spi_pkg::PAGE_COUNT*spi_pkg::WORDS_PER_PAGE-1];

   logic mem_we;                              // Serial write commit strobe.
   logic [spi_pkg::MEM_ADDR_W-1:0] mem_idx;  // Location addressed by the frame.
   logic [15:0] mem_wdata;                    // Word committed by a serial write.
   logic [15:0] mem_rdata;                    // Stored word at mem_idx.
   logic [15:0] frame_word;                   // Completed frame including last bit.
   logic [5:0] frame_wordsel;                 // Word number within the page.
   logic [7:0] frame_data;                    // Data byte of a write frame.

   // Page codes that name real pages; codes one and two are gaps.
   function automatic logic page_valid(input logic [7:0] p);
      page_valid = (p == spi_pkg::PAGE_OUTPUT)
         || ((p >= spi_pkg::PAGE_CONTROL) && (p <= spi_pkg::PAGE_FILTER_LAST));
   endfunction : page_valid

   // Pages whose locations software may write; the output page is read-only.
   function automatic logic page_writable(input logic [7:0] p);
      page_writable = (p >= spi_pkg::PAGE_CONTROL) && (p <= spi_pkg::PAGE_FILTER_LAST);
   endfunction : page_writable

   assign frame_word = {st_ff.rx[spi_pkg::FRAME_BITS-2:0], st_ff.sync2[2]};
   assign frame_wordsel = frame_word[spi_pkg::ADDR_MSB:spi_pkg::ADDR_LSB+1];
   assign frame_data = frame_word[7:0];
   assign mem_idx = {st_ff.page[3:0], frame_wordsel};
   assign mem_rdata = reg_mem[mem_idx];

   // Next-state logic: synchronise pins, find edges, shift and decode frames.
   always_comb
   begin
      logic sclk_rise;
      logic sclk_fall;
      logic ss_low;
      logic ss_fall;
      logic [15:0] rd_val;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      ss_low = 1'b0;
      ss_fall = 1'b0;
      rd_val = '0;
      nxt_st = st_ff;
      mem_we = 1'b0;
      mem_wdata = '0;
      // Pins come from the master's domain, so each passes two flip-flops.
      nxt_st.sync1 = {link.mosi, link.ss_n, link.sclk};
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.sclk_prev = st_ff.sync2[0];
      nxt_st.ss_prev = st_ff.sync2[1];
      sclk_rise = st_ff.sync2[0] && !st_ff.sclk_prev;
      sclk_fall = !st_ff.sync2[0] && st_ff.sclk_prev;
      ss_low = !st_ff.sync2[1];
      ss_fall = st_ff.ss_prev && !st_ff.sync2[1];
      // New sample set complete: one clock-wide high pulse.
      nxt_st.drdy = load_done_in;
      // The output is driven only while the master selects us.
      nxt_st.miso_oe = ss_low;
      // What a read request frame would fetch: whole register, either byte address.
      if (frame_wordsel == spi_pkg::PAGE_SELECT_WORD)
      begin
         rd_val = {8'h00, st_ff.page};
      end
      else if (!page_valid(st_ff.page))
      begin
         rd_val = '0;
      end
      else if ((st_ff.page == spi_pkg::PAGE_OUTPUT)
         && (frame_wordsel == spi_pkg::PRODUCT_CODE_WORD))
      begin
         rd_val = PRODUCT_CODE;
      end
      else
      begin
         rd_val = mem_rdata;
      end
      if (!ss_low)
      begin
         // Deselected: sclk is ignored and a partial frame is thrown away.
         nxt_st.bit_cnt = '0;
         nxt_st.rx = '0;
      end
      else
      begin
         // A new selection restarts transmission with the pending reply.
         if (ss_fall)
         begin
            nxt_st.tx = st_ff.reply;
         end
         // Mode 3: shift out on the falling edge.
         if (sclk_fall)
         begin
            nxt_st.miso = st_ff.tx[spi_pkg::FRAME_BITS-1];
            nxt_st.tx = {st_ff.tx[spi_pkg::FRAME_BITS-2:0], 1'b0};
         end
         // Mode 3: sample on the rising edge, most significant bit first.
         if (sclk_rise)
         begin
            nxt_st.rx = frame_word;
            nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
            // Only the sixteenth rising edge completes a command.
            if (st_ff.bit_cnt == spi_pkg::LAST_BIT)
            begin
               nxt_st.bit_cnt = '0;
               nxt_st.reply = '0;
               nxt_st.tx = '0;
               if (frame_word[spi_pkg::WRITE_FLAG_BIT])
               begin
                  // Write frame: flag, seven address bits, data byte.
                  if (frame_word[spi_pkg::ADDR_MSB:spi_pkg::ADDR_LSB]
                     == spi_pkg::PAGE_SELECT_ADDR)
                  begin
                     nxt_st.page = frame_data;
                  end
                  else if ((frame_wordsel == spi_pkg::PAGE_SELECT_WORD)
                     || !page_writable(st_ff.page))
                  begin
                     // Upper page-select byte and read-only pages ignore writes.
                     nxt_st.pend_valid = st_ff.pend_valid;
                  end
                  else if (!frame_word[spi_pkg::ADDR_LSB])
                  begin
                     // Low byte is only held; the register keeps its value for now.
                     nxt_st.pend_valid = 1'b1;
                     nxt_st.pend_word = frame_wordsel;
                     nxt_st.pend_low = frame_data;
                  end
                  else
                  begin
                     // High byte commits the word together with the held low byte.
                     mem_we = 1'b1;
                     if (st_ff.pend_valid && (st_ff.pend_word == frame_wordsel))
                     begin
                        mem_wdata = {frame_data, st_ff.pend_low};
                     end
                     else
                     begin
                        // Lone high byte: the old low byte is kept.
                        mem_wdata = {frame_data, mem_rdata[7:0]};
                     end
                     nxt_st.pend_valid = 1'b0;
                  end
               end
               else
               begin
                  // Read request: last eight bits ignored, reply goes out next frame.
                  nxt_st.reply = rd_val;
                  nxt_st.tx = rd_val;
               end
            end
         end
      end
   end

   // State register; the clock enable freezes everything while low.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_ff <= DEV_RESET;
      end
      else if (ce_in)
      begin
         st_ff <= nxt_st;
      end
   end

   // Storage is left uninitialised; only written locations hold meaning.
   // Sensor loads target the output page; serial commits never do.
   always_ff @(posedge clk_in)
   begin
      if (ce_in && load_valid_in)
      begin
         reg_mem[{4'h0, load_word_in}] <= load_value_in;
      end
      if (ce_in && mem_we)
      begin
         reg_mem[mem_idx] <= mem_wdata;
      end
   end

   assign link.miso_o = st_ff.miso;
   assign link.miso_oe = st_ff.miso_oe;
   assign link.data_ready = st_ff.drdy;
   assign active_page_out = st_ff.page;

endmodule : spi_reg_device

// ---- hdl/spi_reg_host.sv ----
module spi_reg_host #(
   parameter int SCLK_HALF = spi_pkg::SCLK_HALF_CYCLES
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   spi_link_if.host link
);

   // Refuse a half period the rate limit or the far synchronisers cannot serve.
   generate
      if ((SCLK_HALF < spi_pkg::SCLK_HALF_RATE_MIN) || (SCLK_HALF < spi_pkg::SCLK_HALF_SYNC_MIN)
         || (SCLK_HALF > 255))
      begin : g_bad_half
         $error("SCLK_HALF out of range");
      end
   endgenerate

   localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF - 1);

   // Frame sequencer phases.
   typedef enum logic [2:0] {PH_IDLE, PH_LEAD, PH_LOW, PH_HIGH, PH_TAIL, PH_GAP} phase_t;

   // All state of the controller in one record.
   typedef struct packed {
      logic [1:0] sync1;    // First synchroniser stage: data_ready, miso.
      logic [1:0] sync2;    // Second synchroniser stage.
      logic drdy_prev;      // Synchronised data_ready one cycle back.
      logic pready;         // APB ready.
      logic pslverr;        // APB error for unmapped offsets.
      logic [31:0] prdata;  // APB read data.
      phase_t phase;        // Sequencer phase.
      logic [7:0] half_cnt; // Cycles spent in the current phase.
      logic [4:0] bit_cnt;  // Bits sent in this frame.
      logic [15:0] tx;      // Outgoing command shift register.
      logic [15:0] rx;      // Incoming shift register.
      logic [15:0] rx_last; // Word received by the last finished frame.
      logic done;           // Sticky frame-finished flag.
      logic drdy_seen;      // Sticky data-ready flag.
      logic sclk;           // Serial clock pin.
      logic ss_n;           // Slave select pin.
      logic mosi;           // Serial data pin.
   } host_state_t;

   localparam host_state_t HOST_RESET = '{
      sclk: 1'b1,
      ss_n: 1'b1,
      mosi: 1'b1,
      phase: PH_IDLE,
      default: '0
   };

   host_state_t st_ff; // Registered state.
   host_state_t nxt_st; // Next state.

   // Next-state logic: APB slave in front, frame sequencer behind.
   always_comb
   begin
      logic setup;
      logic access;
      logic half_end;
      logic [31:0] rd_mux;
      setup = psel_in && !penable_in;
      access = psel_in && penable_in && st_ff.pready;
      half_end = (st_ff.half_cnt == HALF_LAST);
      rd_mux = '0;
      nxt_st = st_ff;
      nxt_st.sync1 = {link.data_ready, link.miso};
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.drdy_prev = st_ff.sync2[1];
      // Read mux; status shows busy, done and the data-ready mark.
      case (paddr_in)
         spi_pkg::CMD_OFFSET: rd_mux = {16'h0000, st_ff.tx};
         spi_pkg::STATUS_OFFSET: rd_mux = {29'h0, st_ff.drdy_seen, st_ff.done,
            (st_ff.phase != PH_IDLE)};
         spi_pkg::RX_OFFSET: rd_mux = {16'h0000, st_ff.rx_last};
         default: rd_mux = '0;
      endcase
      // Zero-wait slave: ready and data are prepared during the setup cycle.
      nxt_st.pready = setup;
      nxt_st.pslverr = setup && (paddr_in != spi_pkg::CMD_OFFSET)
         && (paddr_in != spi_pkg::STATUS_OFFSET) && (paddr_in != spi_pkg::RX_OFFSET);
      nxt_st.prdata = (setup && !pwrite_in) ? rd_mux : '0;
      nxt_st.half_cnt = half_end ? 8'h00 : st_ff.half_cnt + 8'h01;
      // Writing one clears a sticky flag; set below wins in the same cycle.
      if (access && pwrite_in && (paddr_in == spi_pkg::STATUS_OFFSET))
      begin
         if (pwdata_in[spi_pkg::STATUS_DONE_BIT])
         begin
            nxt_st.done = 1'b0;
         end
         if (pwdata_in[spi_pkg::STATUS_DRDY_BIT])
         begin
            nxt_st.drdy_seen = 1'b0;
         end
      end
      if (st_ff.sync2[1] && !st_ff.drdy_prev)
      begin
         nxt_st.drdy_seen = 1'b1;
      end
      case (st_ff.phase)
         PH_IDLE:
         begin
            nxt_st.half_cnt = '0;
            // A command write while busy is ignored.
            if (access && pwrite_in && (paddr_in == spi_pkg::CMD_OFFSET))
            begin
               nxt_st.tx = pwdata_in[15:0];
               nxt_st.done = 1'b0;
               nxt_st.ss_n = 1'b0;
               nxt_st.phase = PH_LEAD;
            end
         end
         PH_LEAD:
         begin
            if (half_end)
            begin
               // First falling edge puts the MSB out.
               nxt_st.sclk = 1'b0;
               nxt_st.mosi = st_ff.tx[15];
               nxt_st.tx = {st_ff.tx[14:0], 1'b0};
               nxt_st.phase = PH_LOW;
            end
         end
         PH_LOW:
         begin
            if (half_end)
            begin
               nxt_st.sclk = 1'b1;
               nxt_st.phase = PH_HIGH;
            end
         end
         PH_HIGH:
         begin
            if (half_end)
            begin
               // Sample late in the high phase so the far path delay has settled.
               nxt_st.rx = {st_ff.rx[14:0], st_ff.sync2[0]};
               if (st_ff.bit_cnt == spi_pkg::LAST_BIT)
               begin
                  nxt_st.bit_cnt = '0;
                  nxt_st.phase = PH_TAIL;
               end
               else
               begin
                  nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
                  nxt_st.sclk = 1'b0;
                  nxt_st.mosi = st_ff.tx[15];
                  nxt_st.tx = {st_ff.tx[14:0], 1'b0};
                  nxt_st.phase = PH_LOW;
               end
            end
         end
         PH_TAIL:
         begin
            if (half_end)
            begin
               nxt_st.ss_n = 1'b1;
               nxt_st.mosi = 1'b1;
               nxt_st.rx_last = st_ff.rx;
               nxt_st.phase = PH_GAP;
            end
         end
         PH_GAP:
         begin
            // Deselect long enough for the device to see it.
            if (half_end)
            begin
               nxt_st.done = 1'b1;
               nxt_st.phase = PH_IDLE;
            end
         end
         default:
         begin
            nxt_st.phase = PH_IDLE;
         end
      endcase
   end

   // State register; the clock enable freezes everything while low.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_ff <= HOST_RESET;
      end
      else if (ce_in)
      begin
         st_ff <= nxt_st;
      end
   end

   assign prdata_out = st_ff.prdata;
   assign pready_out = st_ff.pready;
   assign pslverr_out = st_ff.pslverr;
   assign link.sclk = st_ff.sclk;
   assign link.ss_n = st_ff.ss_n;
   assign link.mosi = st_ff.mosi;

endmodule : spi_reg_host

// ---- bench/paged_spi_register_port_sva.sv ----
// Watches the serial link between the two ends; the host runs at the default half period.
module paged_spi_register_port_sva (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic sclk,
   input wire logic ss_n,
   input wire logic mosi,
   input wire logic miso_o,
   input wire logic miso_oe,
   input wire logic miso,
   input wire logic data_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [4:0] rise_cnt_ff; // Rising serial clock edges seen in this frame.
   // Count rising edges while selected, so a short or long frame shows at deselect.
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rise_cnt_ff <= 5'h00;
      else if (ss_n)
         rise_cnt_ff <= 5'h00;
      else if ($rose(sclk))
         rise_cnt_ff <= rise_cnt_ff + 5'h01;
   end
   a_sclk_idle_high: assert property (ss_n |-> sclk)
      else $error("sclk not high while deselected");
   a_sclk_low_half: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
      else $error("sclk low phase not four cycles");
   a_mosi_steady_high: assert property (sclk && $past(sclk) && !ss_n |-> $stable(mosi))
      else $error("mosi moved while sclk high");
   a_frame_bit_count: assert property ($rose(ss_n) |-> rise_cnt_ff == 5'h10)
      else $error("frame did not carry sixteen clocks");
   a_oe_on_select: assert property ($fell(ss_n) |-> ##[1:5] miso_oe)
      else $error("miso not driven after select");
   a_oe_off_release: assert property ($rose(ss_n) |-> ##[1:5] !miso_oe)
      else $error("miso still driven after deselect");
   a_oe_idle_off: assert property (ss_n [*6] |-> !miso_oe)
      else $error("miso driven while idle");
   a_miso_steady_rise: assert property ($rose(sclk) && miso_oe |=> $stable(miso_o))
      else $error("miso moved after sclk rise");
   a_ready_one_pulse: assert property ($rose(data_ready) |=> !data_ready)
      else $error("data ready pulse too long");
   cover property ($rose(ss_n));
   cover property ($rose(data_ready));
   cover property (miso_oe && !miso);
endmodule : paged_spi_register_port_sva

// ---- bench/paged_spi_register_port_tb.sv ----
// Drives the host over APB and checks what comes back across the link.
module paged_spi_register_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, page;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, load_valid = 1'b0, load_done = 1'b0;
   logic [5:0] load_word = 6'h00;
   logic [15:0] load_value = 16'h0000;
   int miscompares = 0, comparisons = 0, seed = 9;
   spi_link_if link ();
   // Clock enables stay high; freezing is not exercised here.
   spi_reg_host u_spi_reg_host (.clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(link.host));
   spi_reg_device u_spi_reg_device (.clk_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
      .link(link.device), .load_valid_in(load_valid), .load_word_in(load_word),
      .load_value_in(load_value), .load_done_in(load_done), .active_page_out(page));
   paged_spi_register_port_sva u_checker (.clk_in(clk), .rst_n_in(rst_n), .sclk(link.sclk),
      .ss_n(link.ss_n), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe(link.miso_oe),
      .miso(link.miso), .data_ready(link.data_ready));
   // Free running 50 ns clock.
   initial
   begin
      forever #25 clk = ~clk;
   end
   // Prints the counts and the verdict, then stops.
   task automatic finish_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // A wait that ran out counts as a mismatch and ends the run.
   task automatic hang();
      miscompares++;
      $display("[ERR] wait exp done got timeout");
      finish_test();
   endtask : hang
   // Compares one 16-bit result.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask : chk
   // Expected read of the page-select register: the page code in the low byte.
   function automatic logic [15:0] exp_page(input logic [7:0] code);
      return {8'h00, code};
   endfunction : exp_page
   // Expected register word from its upper and lower byte writes.
   function automatic logic [15:0] exp_word(input logic [7:0] hi, input logic [7:0] lo);
      return {hi, lo};
   endfunction : exp_word
   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         hang();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // One idle edge keeps two transfers from touching psel in one time step.
      @(posedge clk);
   endtask : apb
   // Sends one frame, waits for done, clears it and returns the received word.
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      logic [31:0] q;
      logic e;
      int n;
      n = 0;
      apb(1'b1, spi_pkg::CMD_OFFSET, {16'h0000, w}, q, e);
      do
      begin
         apb(1'b0, spi_pkg::STATUS_OFFSET, 32'h0, q, e);
         n++;
      end while (q[spi_pkg::STATUS_DONE_BIT] !== 1'b1 && n < 100);
      if (n >= 100)
         hang();
      apb(1'b1, spi_pkg::STATUS_OFFSET, 32'h2, q, e);
      apb(1'b0, spi_pkg::RX_OFFSET, 32'h0, q, e);
      r = q[15:0];
   endtask : xfer
   // A read needs a second frame, which carries the reply.
   task automatic rd(input logic [6:0] a, output logic [15:0] v);
      logic [15:0] r;
      xfer({1'b0, a, 8'h00}, r);
      xfer({1'b0, a, 8'h00}, v);
   endtask : rd
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [15:0] r;
      xfer({1'b1, a, d}, r);
   endtask : wr
   initial
   begin
      logic [15:0] v, v1, v2;
      logic [31:0] q;
      logic e;
      logic [6:0] a;
      logic [7:0] codes [4];
      codes = '{8'h03, 8'h04, 8'h05, 8'h0C};
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(7'h00, v);
      chk("page after reset", 16'h0000, v);
      // Repeated reads of either byte return the same fixed word.
      for (int i = 0; i < 3; i++)
      begin
         rd(7'h7E | 7'(i == 2), v);
         chk("product code", spi_pkg::PRODUCT_CODE_DEFAULT, v);
      end
      $display("defaults done");
      foreach (codes[i])
      begin
         wr(7'h00, codes[i]);
         chk("active page", exp_page(codes[i]), {8'h00, page});
         rd(7'h00, v);
         chk("page read", exp_page(codes[i]), v);
      end
      // The upper byte of page select takes no writes, so the page stays.
      wr(7'h01, 8'hFF);
      chk("page upper byte", exp_page(8'h0C), {8'h00, page});
      $display("paging done");
      // Random even address on the last filter page; the two values differ in every bit.
      q = $random(seed);
      a = {1'b0, q[4:0], 1'b0} | 7'h02;
      v1 = q[23:8];
      v2 = ~q[23:8];
      wr(a, v1[7:0]);
      wr(a | 7'h01, v1[15:8]);
      rd(a, v);
      chk("word write", exp_word(v1[15:8], v1[7:0]), v);
      wr(a, v2[7:0]);
      rd(a, v);
      chk("low byte held", v1, v);
      wr(a | 7'h01, v2[15:8]);
      rd(a | 7'h01, v);
      chk("high commit", v2, v);
      // A lone upper byte with no held lower byte keeps the stored lower byte.
      wr(a | 7'h01, v1[15:8]);
      rd(a, v);
      chk("lone high byte", exp_word(v1[15:8], v2[7:0]), v);
      wr(7'h00, 8'h01);
      rd(a, v);
      chk("unused page", 16'h0000, v);
      wr(7'h00, 8'h00);
      $display("byte writes done");
      q = $random(seed);
      load_valid <= 1'b1;
      load_word <= 6'h05;
      load_value <= q[15:0];
      @(posedge clk);
      load_valid <= 1'b0;
      rd(7'h0A, v);
      chk("sensor word", q[15:0], v);
      wr(7'h0A, ~q[7:0]);
      wr(7'h0B, ~q[15:8]);
      rd(7'h0A, v);
      chk("read only", q[15:0], v);
      $display("output page done");
      apb(1'b1, spi_pkg::STATUS_OFFSET, 32'h4, q, e);
      load_done <= 1'b1;
      @(posedge clk);
      load_done <= 1'b0;
      for (int i = 0; i < 10 && q[spi_pkg::STATUS_DRDY_BIT] !== 1'b1; i++)
         apb(1'b0, spi_pkg::STATUS_OFFSET, 32'h0, q, e);
      chk("data ready", 16'h0001, {15'h0000, q[spi_pkg::STATUS_DRDY_BIT]});
      apb(1'b0, 8'h0C, 32'h0, q, e);
      chk("unmapped error", 16'h0001, {15'h0000, e});
      chk("unmapped data", 16'h0000, q[15:0]);
      $display("status done");
      finish_test();
   end
endmodule : paged_spi_register_port_tb
